/* core/ttm_top.sv */
/*
  throttle input logic, second alert mask, alert pin routing,
  shared pin multiplexer, full speed override and the cumulative
  throttle timer, as an apb slave.
  assumes fault and stall conditions arrive as synchronous levels
  and fan drive logic outside honours the full speed request.
*/
// Operation
// R1 - mask bits seven, six gate diode faults
// R2 - mask bit five gates fourth source
// R3 - mask bits four to two gate fans
// R4 - mask bit one gates overtemperature
// R5 - mask bit zero gates twelve volt
// R6 - alert routing disabled after reset
// R7 - config three selects fan two alert
// R8 - config four selects shared pin role
// R9 - throttle enable activates throttle pins
// R10 - disabled throttle gives voltage input
// R11 - full speed while throttle held low
// R12 - override only for running fans
// R13 - timer accumulates across assertions
// R14 - timer saturates until read clears
// R15 - bit zero marks first assertion
// R16 - timer read returns and clears
// R17 - timer read clears fourth flag
// R18 - read during assertion restarts at one
// R19 - zero limit sets flag again
// R20 - mask never stops status bits
// R21 - timer over limit sets flag
// R22 - alert holds until status read, except overtemperature
// R23 - throttle pin active low, synchronised
`timescale 1ns/100ps
`include "ttm_regs.svh"

module ttm_top
  import ttm_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = `TTM_STEP_US * `TTM_CLK_MHZ
) (
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rstn,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // monitored conditions
  input  wire logic        i_diode_two_fault,
  input  wire logic        i_diode_one_fault,
  input  wire logic        i_fourth_fan_stall,
  input  wire logic        i_third_fan_stall,
  input  wire logic        i_second_fan_stall,
  input  wire logic        i_first_fan_stall,
  input  wire logic        i_overtemp_flag,
  input  wire logic        i_twelve_volt_or_id_change,
  input  wire logic        i_general_io_six,
  // throttle pins, active low
  input  wire logic        i_throttle_pin_n,
  input  wire logic        i_shared_pin,
  // fans
  input  wire logic        i_second_fan_drive,
  input  wire logic [3:0]  i_fan_running,
  output logic      [3:0]  o_fan_full,
  // pins
  output logic             o_second_fan_pin,
  output logic             o_shared_pin_out,
  output logic             o_shared_pin_oe_n,
  output logic             o_volt_input_sel
);

  // ========================================================
  // parameter check: the prescaler is only twenty bits wide
  if (STEP_CYCLES < 1 || STEP_CYCLES > 1048576) begin : g_step_chk
    $error("STEP_CYCLES outside 1 to 2**20");
  end

  localparam logic [19:0] STEP_LAST = 20'(STEP_CYCLES - 1);

  localparam ttm_state_t RST_STATE = '{
    mask2:    `TTM_RST_MASK_TWO,
    cfg3:     `TTM_RST_CONFIG_THREE,
    cfg4:     `TTM_RST_CONFIG_FOUR,
    limit:    `TTM_RST_TIME_LIMIT,
    ticks:    8'h00,
    seen:     1'b0,
    pre:      20'h00000,
    stat:     8'h00,
    ded_sync: 2'h3,
    sh_sync:  2'h3,
    fan_full: 4'h0,
    prdata:   32'h00000000
  };

  ttm_state_t    st;
  ttm_state_t    nx;
  ttm_pin_mode_t mode;
  logic [9:0]    idx;
  logic          mapped;
  logic          setup;
  logic          wr;
  logic          rd;
  logic          rd_timer;
  logic          rd_stat;
  logic          thr;
  logic          alert;
  logic [7:0]    tval;
  logic [7:0]    next_tval;
  logic          exceed;
  logic [7:0]    cond;

  // ========================================================
  // apb decode; zero wait states, so pready is always high.
  // read data is snapshotted in the setup cycle, so a timer
  // step landing between setup and access is lost to the clear;
  // one step per read is cheaper than a second holding register
  assign idx    = i_paddr[11:2];
  assign setup  = i_psel && !i_penable;
  assign wr     = i_psel && i_penable && i_pwrite;
  assign rd     = i_psel && i_penable && !i_pwrite;
  always_comb begin
    case (idx)
      `TTM_IDX_STATUS_TWO,
      `TTM_IDX_MASK_TWO,
      `TTM_IDX_CONFIG_THREE,
      `TTM_IDX_TIME_STATUS,
      `TTM_IDX_TIME_LIMIT,
      `TTM_IDX_CONFIG_FOUR: mapped = (i_paddr[1:0] == 2'h0);
      default:              mapped = 1'b0;
    endcase
  end
  assign rd_timer  = rd && mapped && idx == `TTM_IDX_TIME_STATUS;
  assign rd_stat   = rd && mapped && idx == `TTM_IDX_STATUS_TWO;
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel && i_penable && !mapped;
  assign o_prdata  = st.prdata;

  // ========================================================
  // throttle detection on synchronised, active low pins
  assign mode = ttm_pin_mode_t'(st.cfg4[1:0]);        // R8
  assign thr  = st.cfg3[`TTM_CFG3_THROTTLE_EN] &&     // R9 R10
                (!st.ded_sync[1] ||                   // R23
                 (mode == TTM_PIN_THROTTLE && !st.sh_sync[1]));
  assign o_volt_input_sel = !st.cfg3[`TTM_CFG3_THROTTLE_EN]; // R10

  // ========================================================
  // reported timer value: one on first assertion, else steps
  assign tval = (st.ticks == 8'h00 && st.seen) ? 8'h01 // R15
                                               : st.ticks;

  // ========================================================
  // alert: any unmasked sticky status bit pulls it
  assign alert = |(st.stat & ~st.mask2);              // R1 R3 R4 R5
  assign o_second_fan_pin =
    st.cfg3[`TTM_CFG3_ALERT_SEL] ? !alert             // R7 R6
                                 : i_second_fan_drive;
  // open drain: only ever pulls low
  assign o_shared_pin_out  = 1'b0;
  assign o_shared_pin_oe_n = !(mode == TTM_PIN_ALERT && alert); // R8
  assign o_fan_full        = st.fan_full;

  // ========================================================
  // next state
  always_comb begin
    nx = st;
    next_tval = 8'h00;
    // two flop synchronisers, first stage read only by second
    nx.ded_sync = {st.ded_sync[0], i_throttle_pin_n};  // R23
    nx.sh_sync  = {st.sh_sync[0], i_shared_pin};
    // register writes
    if (wr && mapped) begin
      case (idx)
        `TTM_IDX_MASK_TWO:     nx.mask2 = i_pwdata[7:0];
        `TTM_IDX_CONFIG_THREE: nx.cfg3  = i_pwdata[7:0];
        `TTM_IDX_TIME_LIMIT:   nx.limit = i_pwdata[7:0];
        `TTM_IDX_CONFIG_FOUR:  nx.cfg4  = i_pwdata[7:0];
        default:               nx.cfg4  = st.cfg4;
      endcase
    end
    // read data captured in the setup cycle
    if (setup) begin
      case (idx)
        `TTM_IDX_STATUS_TWO:   nx.prdata = {24'h0, st.stat};
        `TTM_IDX_MASK_TWO:     nx.prdata = {24'h0, st.mask2};
        `TTM_IDX_CONFIG_THREE: nx.prdata = {24'h0, st.cfg3};
        `TTM_IDX_TIME_STATUS:  nx.prdata = {24'h0, tval}; // R16
        `TTM_IDX_TIME_LIMIT:   nx.prdata = {24'h0, st.limit};
        `TTM_IDX_CONFIG_FOUR:  nx.prdata = {24'h0, st.cfg4};
        default:               nx.prdata = 32'h00000000;
      endcase
    end
    // cumulative timer: runs while asserted, holds otherwise
    if (thr) begin                                     // R13
      nx.seen = 1'b1;
      if (st.pre == STEP_LAST) begin
        nx.pre = 20'h00000;
        if (st.ticks != 8'hFF) begin                   // R14
          nx.ticks = st.ticks + 8'h01;
        end
      end else begin
        nx.pre = st.pre + 20'h00001;
      end
    end
    // read clears; an ongoing assertion marks one again
    if (rd_timer) begin                                // R16 R18
      nx.ticks = 8'h00;
      nx.pre   = 20'h00000;
      nx.seen  = thr;
    end
    next_tval = (nx.ticks == 8'h00 && nx.seen) ? 8'h01 : nx.ticks;
    // compare on the new value so a read can clear the flag
    exceed = next_tval > st.limit;                     // R21 R19
    // fourth source follows the shared pin role
    case (mode)                                        // R2
      TTM_PIN_TACH: cond[5] = i_fourth_fan_stall || exceed;
      TTM_PIN_GPIO: cond[5] = i_general_io_six || exceed;
      default:      cond[5] = exceed;
    endcase
    cond[7] = i_diode_two_fault;
    cond[6] = i_diode_one_fault;
    cond[4] = i_third_fan_stall;
    cond[3] = i_second_fan_stall;
    cond[2] = i_first_fan_stall;
    cond[1] = i_overtemp_flag;
    cond[0] = i_twelve_volt_or_id_change;
    // sticky bits: set wins over the read clear; mask ignored
    nx.stat = cond | (st.stat & {8{!rd_stat}});        // R20 R22
    nx.stat[5] = cond[5] ||                            // R17
                 (st.stat[5] && !rd_stat && !rd_timer);
    // overtemperature follows its condition, never sticky
    nx.stat[1] = cond[1];                              // R4
    // full speed only for fans already running
    nx.fan_full = (thr && st.cfg3[`TTM_CFG3_FULL_SPEED]) ? // R11
                  i_fan_running : 4'h0;                // R12
  end

  // ========================================================
  // state register
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st <= RST_STATE;                                 // R6
    end else begin
      st <= nx;
    end
  end

  // ========================================================
  // checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);

  diode_mask_a: assert property (                      // R1
    (st.stat[7:6] != 2'h0) && (st.mask2[7:6] == 2'h3) &&
    ((st.stat[5:0] & ~st.mask2[5:0]) == 6'h00) |-> !alert)
    else $error("masked diode fault raised alert");

  fourth_mask_a: assert property (                     // R2
    st.stat[5] && !st.mask2[5] |-> alert)
    else $error("unmasked fourth source gave no alert");

  fan_mask_a: assert property (                        // R3
    st.stat[4:2] != 3'h0 && st.mask2[4:2] == 3'h0 |-> alert)
    else $error("unmasked fan stall gave no alert");

  volt_mask_a: assert property (                       // R5
    st.stat == 8'h01 && st.mask2[0] |-> !alert)
    else $error("masked voltage event raised alert");

  pin_route_a: assert property (                       // R7
    st.cfg3[`TTM_CFG3_ALERT_SEL] && alert |-> !o_second_fan_pin)
    else $error("alert not on fan two pin");

  shared_alert_a: assert property (                    // R8
    mode == TTM_PIN_ALERT && alert |-> !o_shared_pin_oe_n)
    else $error("shared pin not pulling alert");

  full_speed_a: assert property (                      // R11 R12
    thr && st.cfg3[`TTM_CFG3_FULL_SPEED] |=>
    o_fan_full == $past(i_fan_running))
    else $error("full speed override wrong");

  timer_hold_a: assert property (                      // R13
    !thr && !rd_timer |=> $stable(tval))
    else $error("timer moved while not asserted");

  timer_sat_a: assert property (                       // R14
    st.ticks == 8'hFF && !rd_timer |=> st.ticks == 8'hFF)
    else $error("timer left full scale");

  read_clear_a: assert property (                      // R16
    rd_timer && !thr |=> tval == 8'h00)
    else $error("timer not cleared by read");

  read_during_a: assert property (                     // R18
    rd_timer && thr |=> tval == 8'h01)
    else $error("timer not one after read in assertion");

  zero_limit_a: assert property (                      // R19
    rd_timer && thr && st.limit == 8'h00 |=> st.stat[5])
    else $error("zero limit flag not set again");

  sticky_hold_a: assert property (                     // R22
    st.stat[2] && !rd_stat |=> st.stat[2] [*1])
    else $error("sticky status lost without read");

  sync_path_a: assert property (                       // R23
    (st.cfg3[`TTM_CFG3_THROTTLE_EN] && !i_throttle_pin_n) [*2]
    |=> thr)
    else $error("low throttle pin not seen in two cycles");

  overtemp_clear_a: assert property (                  // R4
    !i_overtemp_flag |=> !st.stat[1])
    else $error("overtemperature status stuck");

  masked_status_a: assert property (                   // R20
    i_diode_two_fault && st.mask2[7] |=> st.stat[7])
    else $error("masked fault lost its status bit");

  limit_flag_a: assert property (                      // R21
    exceed |=> st.stat[5])
    else $error("timer over limit left flag clear");

  read_flag_clr_a: assert property (                   // R17
    rd_timer && !exceed && !i_fourth_fan_stall && !i_general_io_six
    |=> !st.stat[5])
    else $error("timer read left fourth flag set");

  thr_disable_a: assert property (                     // R10
    !st.cfg3[`TTM_CFG3_THROTTLE_EN] |-> !thr)
    else $error("throttle seen while disabled");

  shared_role_a: assert property (                     // R9
    st.ded_sync[1] && mode != TTM_PIN_THROTTLE |-> !thr)
    else $error("shared pin throttled outside its role");

  timer_run_c: cover property (thr [*3] ##1 !thr ##1 thr);
  read_busy_c: cover property (rd_timer && thr);
  alert_pin_c: cover property (mode == TTM_PIN_ALERT && alert);
  over_limit_c: cover property (exceed && st.limit != 8'h00);
  full_speed_on_throttle_run_c: cover property (o_fan_full != 4'h0);

endmodule

/* core/ttm_regs.svh */
/*
  register offsets, field positions, reset values and timing counts
  of the throttle timer and alert mask block.
  assumes inclusion by the block and the bench only.
*/
`ifndef TTM_REGS_SVH
`define TTM_REGS_SVH

// ==========================================================
// register indices (byte address is four times the index)
`define TTM_IDX_STATUS_TWO    10'h042
`define TTM_IDX_MASK_TWO      10'h075
`define TTM_IDX_CONFIG_THREE  10'h078
`define TTM_IDX_TIME_STATUS   10'h079
`define TTM_IDX_TIME_LIMIT    10'h07A
`define TTM_IDX_CONFIG_FOUR   10'h07D

// ==========================================================
// field positions
`define TTM_CFG3_ALERT_SEL    0
`define TTM_CFG3_THROTTLE_EN  1
`define TTM_CFG3_FULL_SPEED   2
`define TTM_MASK_DIODE_TWO    7
`define TTM_MASK_DIODE_ONE    6
`define TTM_MASK_FOURTH       5
`define TTM_MASK_FAN_THREE    4
`define TTM_MASK_FAN_TWO      3
`define TTM_MASK_FAN_ONE      2
`define TTM_MASK_OVERTEMP     1
`define TTM_MASK_TWELVE_VOLT  0

// ==========================================================
// reset values
`define TTM_RST_MASK_TWO      8'h00
`define TTM_RST_CONFIG_THREE  8'h00
`define TTM_RST_CONFIG_FOUR   8'h00
`define TTM_RST_TIME_LIMIT    8'h00

// ==========================================================
// timing: one timer step in microseconds, clock in MHz
`define TTM_STEP_US           22760
`define TTM_CLK_MHZ           40

`endif

/* core/ttm_pkg.sv */
/*
  types of the throttle timer and alert mask block.
  assumes compilation ahead of the block; needs nothing from ttm_regs.svh.
*/
package ttm_pkg;

  // ========================================================
  // role of the shared multi-function pin
  typedef enum logic [1:0] {
    TTM_PIN_TACH,
    TTM_PIN_THROTTLE,
    TTM_PIN_ALERT,
    TTM_PIN_GPIO
  } ttm_pin_mode_t;

  // ========================================================
  // whole state of the block
  typedef struct packed {
    logic [7:0]  mask2;
    logic [7:0]  cfg3;
    logic [7:0]  cfg4;
    logic [7:0]  limit;
    logic [7:0]  ticks;
    logic        seen;
    logic [19:0] pre;
    logic [7:0]  stat;
    logic [1:0]  ded_sync;
    logic [1:0]  sh_sync;
    logic [3:0]  fan_full;
    logic [31:0] prdata;
  } ttm_state_t;

endpackage

/* verification/ttm_hot_model.sv */
/*
  far side model: hot signal of a processor or a trip point sensor
  pulling the throttle pin low. assumes a pull-up on the line.
*/
`timescale 1ns/100ps

module ttm_hot_model (
  // clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_rstn,
  // command from the bench
  input  wire logic       i_hold,
  input  wire logic [3:0] i_lag,
  // open drain line, low while asserted
  output logic            o_throttle_pin_n
);
  logic [3:0] lag_cnt;

  // ==========================================================
  // assert after i_lag cycles; released line floats high
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      lag_cnt          <= 4'h0;
      o_throttle_pin_n <= 1'b1;
    end else if (!i_hold) begin
      lag_cnt          <= 4'h0;
      o_throttle_pin_n <= 1'b1; // pull-up wins once let go
    end else if (lag_cnt < i_lag) begin
      lag_cnt <= lag_cnt + 4'h1; // slow answer
    end else begin
      o_throttle_pin_n <= 1'b0;
    end
  end
endmodule

/* verification/test_throttle_timer_alert_mask.sv */
/*
  bench of the throttle timer and alert mask block over apb.
  assumes a one-cycle pulse width is never asked of the sync.
*/
`timescale 1ns/100ps
`include "ttm_regs.svh"

module test_throttle_timer_alert_mask;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  cond = 8'h00;
  logic        sh_n = 1'b1;
  logic        gio = 1'b0;
  logic        drv = 1'b1;
  logic        hold = 1'b0;
  logic [3:0]  run = 4'h5;
  logic [3:0]  lag = 4'h0;
  logic [3:0]  full;
  logic        thr_n;
  logic        fpin;
  logic        oe_n;
  logic        vsel;
  logic        spo;
  logic [31:0] d;
  logic        e;
  int          error_cnt = 0;
  int          cmp_count = 0;

  // ==========================================================
  // clock, partner and design
  always #12.5 clk = ~clk;

  ttm_hot_model hot (.i_ref_clk(clk), .i_rstn(rstn), .i_hold(hold),
    .i_lag(lag), .o_throttle_pin_n(thr_n));

  ttm_top #(.STEP_CYCLES(8)) DUT (
    .i_ref_clk(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_diode_two_fault(cond[7]), .i_diode_one_fault(cond[6]),
    .i_fourth_fan_stall(cond[5]), .i_third_fan_stall(cond[4]),
    .i_second_fan_stall(cond[3]), .i_first_fan_stall(cond[2]),
    .i_overtemp_flag(cond[1]), .i_twelve_volt_or_id_change(cond[0]),
    .i_general_io_six(gio), .i_throttle_pin_n(thr_n),
    .i_shared_pin(sh_n), .i_second_fan_drive(drv),
    .i_fan_running(run), .o_fan_full(full), .o_second_fan_pin(fpin),
    .o_shared_pin_out(spo), .o_shared_pin_oe_n(oe_n),
    .o_volt_input_sel(vsel));

  // ==========================================================
  // bus cycles and comparison
  task automatic apb(input logic w, input logic [9:0] i,
                     input logic [7:0] v);
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= {i, 2'b00};
    pwdata <= {24'h0, v};
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    cmp_count++;
    if (s !== x) begin
      error_cnt++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask

  task automatic wr(input logic [9:0] i, input logic [7:0] v);
    apb(1'b1, i, v);
  endtask

  // read and compare in one go
  task automatic rdc(input logic [9:0] i, input logic [7:0] x);
    apb(1'b0, i, 8'h00);
    chk(d, {24'h0, x});
  endtask

  task automatic wn(input int n);
    repeat (n) @(posedge clk);
  endtask

  // assert throttle on the dedicated or the shared pin for n cycles
  task automatic pulse(input int n, input logic s);
    if (s) sh_n <= 1'b0;
    else hold <= 1'b1;
    wn(n);
    sh_n <= 1'b1;
    hold <= 1'b0;
    wn(6);
  endtask

  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ==========================================================
  // watchdog, far above the planned run of about 2800 cycles
  initial begin
    #(25 * 20000);
    error_cnt++;
    end_sim();
  end

  // ==========================================================
  // tests
  initial begin
    wn(16);
    rstn <= 1'b1;
    rdc(`TTM_IDX_MASK_TWO, 8'h00);
    rdc(`TTM_IDX_CONFIG_THREE, 8'h00);
    rdc(`TTM_IDX_CONFIG_FOUR, 8'h00);
    chk(32'({fpin, oe_n, vsel, spo}), 32'hE);
    apb(1'b0, 10'h000, 8'h00);
    chk(32'({e, pready, d[7:0]}), 32'h300);
    wr(`TTM_IDX_MASK_TWO, 8'hA5);
    rdc(`TTM_IDX_MASK_TWO, 8'hA5);
    for (int k = 0; k < 4; k++) begin
      wr(`TTM_IDX_CONFIG_FOUR, 8'(k));
      rdc(`TTM_IDX_CONFIG_FOUR, 8'(k));
    end
    $display("test registers done");
    // each alert source masked, then unmasked, then cleared
    wr(`TTM_IDX_CONFIG_FOUR, 8'h00);
    wr(`TTM_IDX_CONFIG_THREE, 8'h01);
    for (int i = 0; i < 8; i++) begin
      wr(`TTM_IDX_MASK_TWO, 8'h01 << i);
      cond <= 8'h01 << i;
      wn(4);
      chk(32'(fpin), 32'h1);
      rdc(`TTM_IDX_STATUS_TWO, 8'h01 << i);
      wr(`TTM_IDX_MASK_TWO, 8'h00);
      wn(2);
      chk(32'(fpin), 32'h0);
      cond <= 8'h00;
      wn(3);
      chk(32'(fpin), 32'(i == 1));
      rdc(`TTM_IDX_STATUS_TWO, (i == 1) ? 8'h00 : 8'h01 << i);
      wn(1);
      chk(32'(fpin), 32'h1);
    end
    // fourth source follows the shared pin role
    wr(`TTM_IDX_CONFIG_FOUR, 8'h03);
    wr(`TTM_IDX_MASK_TWO, 8'h20);
    gio <= 1'b1;
    wn(2);
    chk(32'(fpin), 32'h1);
    wr(`TTM_IDX_MASK_TWO, 8'h00);
    wn(1);
    chk(32'(fpin), 32'h0);
    gio <= 1'b0;
    rdc(`TTM_IDX_STATUS_TWO, 8'h20);
    rdc(`TTM_IDX_STATUS_TWO, 8'h00);
    wr(`TTM_IDX_CONFIG_FOUR, 8'h01);
    cond <= 8'h20;
    wn(3);
    rdc(`TTM_IDX_STATUS_TWO, 8'h00);
    cond <= 8'h00;
    wr(`TTM_IDX_CONFIG_THREE, 8'h00);
    drv <= 1'b0;
    wn(1);
    chk(32'(fpin), 32'h0);
    wr(`TTM_IDX_CONFIG_FOUR, 8'h02);
    cond <= 8'h80;
    wn(3);
    chk(32'({oe_n, spo}), 32'h0);
    wr(`TTM_IDX_CONFIG_FOUR, 8'h03);
    wn(1);
    chk(32'(oe_n), 32'h1);
    cond <= 8'h00;
    wr(`TTM_IDX_CONFIG_FOUR, 8'h00);
    apb(1'b0, `TTM_IDX_STATUS_TWO, 8'h00);
    $display("test alert routing done");
    // timer counts, override, clear on read
    wr(`TTM_IDX_CONFIG_THREE, 8'h06);
    hold <= 1'b1;
    wn(12);
    chk(32'(full), 32'h5);
    wn(8);
    hold <= 1'b0;
    wn(6);
    chk(32'(full), 32'h0);
    rdc(`TTM_IDX_TIME_STATUS, 8'h02);
    rdc(`TTM_IDX_TIME_STATUS, 8'h00);
    pulse(13, 1'b0);
    pulse(13, 1'b0);
    rdc(`TTM_IDX_TIME_STATUS, 8'h03);
    lag <= 4'h5;
    pulse(8, 1'b0);
    rdc(`TTM_IDX_TIME_STATUS, 8'h01);
    lag <= 4'h0;
    $display("test timer done");
    // limit exceeded, flag and alert, cleared by timer read
    wr(`TTM_IDX_TIME_LIMIT, 8'h01);
    wr(`TTM_IDX_CONFIG_THREE, 8'h07);
    pulse(20, 1'b0);
    chk(32'(fpin), 32'h0);
    rdc(`TTM_IDX_STATUS_TWO, 8'h20);
    rdc(`TTM_IDX_TIME_STATUS, 8'h02);
    rdc(`TTM_IDX_STATUS_TWO, 8'h00);
    // read in mid assertion with a zero limit
    wr(`TTM_IDX_TIME_LIMIT, 8'h00);
    hold <= 1'b1;
    wn(40);
    apb(1'b0, `TTM_IDX_TIME_STATUS, 8'h00);
    rdc(`TTM_IDX_TIME_STATUS, 8'h01);
    rdc(`TTM_IDX_STATUS_TWO, 8'h20);
    wn(2200);
    rdc(`TTM_IDX_TIME_STATUS, 8'hFF);
    hold <= 1'b0;
    wn(6);
    apb(1'b0, `TTM_IDX_TIME_STATUS, 8'h00);
    $display("test limit done");
    // throttle disabled, then on the shared pin
    wr(`TTM_IDX_CONFIG_THREE, 8'h00);
    wr(`TTM_IDX_CONFIG_FOUR, 8'h01);
    pulse(20, 1'b0);
    pulse(20, 1'b1);
    chk(32'(vsel), 32'h1);
    rdc(`TTM_IDX_TIME_STATUS, 8'h00);
    wr(`TTM_IDX_CONFIG_THREE, 8'h02);
    pulse(20, 1'b1);
    chk(32'(vsel), 32'h0);
    rdc(`TTM_IDX_TIME_STATUS, 8'h02);
    wr(`TTM_IDX_CONFIG_FOUR, 8'h00);
    pulse(20, 1'b1);
    rdc(`TTM_IDX_TIME_STATUS, 8'h00);
    $display("test pin roles done");
    end_sim();
  end
endmodule
